// [shared/apc_pkg.sv]
// Purpose: shared constants and types of the post-conversion compute block
// Assumes: 8-bit register port, 12-bit conversion results
// Notes: offsets are word indices on the plain register port
package apc_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int RES_W = 12;
    localparam int ACC_W = 16;
    localparam int CS_W = 6;
    localparam int CNT_W = 8;
    // register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CALC = 4'h1;
    localparam logic [3:0] ADDR_CLK = 4'h2;
    localparam logic [3:0] ADDR_REF = 4'h3;
    localparam logic [3:0] ADDR_RPT = 4'h4;
    localparam logic [3:0] ADDR_CNT = 4'h5;
    localparam logic [3:0] ADDR_ACC_LO = 4'h6;
    localparam logic [3:0] ADDR_ACC_HI = 4'h7;
    localparam logic [3:0] ADDR_THR_LO = 4'h8;
    localparam logic [3:0] ADDR_THR_HI = 4'h9;
    localparam logic [3:0] ADDR_STATUS = 4'hA;
    localparam logic [3:0] ADDR_MASK = 4'hB;
    // field positions
    localparam int CTRL_DSEN_BIT = 3;
    localparam int CTRL_COND_LSB = 4;
    localparam int REF_NEGATIVE_REF_SELECT_BIT = 4;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_THR_BIT = 1;
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    // positive reference codes
    localparam logic [1:0] POSITIVE_REF_SELECT_SUPPLY = 2'h0;
    localparam logic [1:0] POSITIVE_REF_SELECT_RESERVED = 2'h1;
    localparam logic [1:0] POSITIVE_REF_SELECT_EXTERNAL = 2'h2;
    localparam logic [1:0] POSITIVE_REF_SELECT_FIXED = 2'h3;
    // threshold comparison conditions
    localparam logic [1:0] COND_NEVER = 2'h0;
    localparam logic [1:0] COND_BELOW = 2'h1;
    localparam logic [1:0] COND_AT_OR_ABOVE = 2'h2;
    localparam logic [1:0] COND_ALWAYS = 2'h3;

    typedef enum logic [2:0] {
        APC_BASIC = 3'h0,
        APC_ACCUMULATE = 3'h1,
        APC_AVERAGE = 3'h2,
        APC_BURST = 3'h3,
        APC_LOWPASS = 3'h4
    } apc_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_WAIT = 3'b100
    } apc_state_t;

    // unused field codes fall back to basic mode
    function automatic apc_mode_t apc_decode_mode(input logic [2:0] f);
        apc_mode_t m;
        m = APC_BASIC;
        if (f <= 3'h4) begin
            m = apc_mode_t'(f);
        end
        return m;
    endfunction : apc_decode_mode
endpackage : apc_pkg

// [shared/apc_test_if.sv]
// Purpose: threshold test request between the engine and the comparator
// Assumes: one clock domain
// Notes: strobe and pass are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface apc_test_if #(parameter int W = 16);
    logic strobe;
    logic [W-1:0] value;
    logic [W-1:0] limit;
    logic [1:0] cond;
    logic pass;
    modport req (output strobe, output value, output limit, output cond, input pass);
    modport cmp (input strobe, input value, input limit, input cond, output pass);
endinterface : apc_test_if
`default_nettype wire

// [rtl/apc_clk_div.sv]
// Purpose: conversion clock from the oscillator clock
// Assumes: select may change at any time; the count wraps safely
// Notes: period is two times (select plus one) oscillator cycles
`timescale 1ns/10ps
`default_nettype none
module apc_clk_div import apc_pkg::*; #(
    parameter int SEL_W = CS_W
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [SEL_W-1:0] sel_in,
    output logic conv_clk_out
);
    logic [SEL_W-1:0] cnt;
    logic [SEL_W-1:0] next_cnt;
    logic next_clk;

    generate
        if (SEL_W < 1) begin : g_bad_width
            $error("apc_clk_div: SEL_W must be at least 1");
        end
    endgenerate

    // half period ends when the count reaches the select value
    always_comb begin
        next_cnt = SEL_W'(cnt + 1'b1);
        next_clk = conv_clk_out;
        if (cnt >= sel_in) begin
            next_cnt = '0;
            next_clk = ~conv_clk_out;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= '0;
            conv_clk_out <= 1'b0;
        end else begin
            cnt <= next_cnt;
            conv_clk_out <= next_clk;
        end
    end

    half_period_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cnt == sel_in) |=> (conv_clk_out != $past(conv_clk_out)) && (cnt == '0))
        else $error("conversion clock half period wrong");
endmodule : apc_clk_div
`default_nettype wire

// [rtl/apc_thresh.sv]
// Purpose: threshold comparison of the computed value
// Assumes: one request at a time, answered one cycle later
// Notes: pass is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module apc_thresh import apc_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    apc_test_if.cmp test
);
    logic next_pass;

    // compare under the configured condition
    always_comb begin
        next_pass = 1'b0;
        if (test.strobe) begin
            case (test.cond)
                COND_BELOW: next_pass = (test.value < test.limit);
                COND_AT_OR_ABOVE: next_pass = (test.value >= test.limit);
                COND_ALWAYS: next_pass = 1'b1;
                default: next_pass = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            test.pass <= 1'b0;
        end else begin
            test.pass <= next_pass;
        end
    end

    cond_always_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (test.strobe && test.cond == COND_ALWAYS) |=> test.pass)
        else $error("always condition did not pass");
endmodule : apc_thresh
`default_nettype wire

// [rtl/apc_post_compute.sv]
// Purpose: post-conversion compute engine with clock and reference select
// Assumes: converter core on the same clock; trigger and done are pulses
// Notes: register port answers a read in the following cycle
//
// Contract
// - Engine works in one of five modes picked by a 3-bit field.
// - Basic mode converts once, or twice with double sample; done after last.
// - Accumulate mode: each trigger adds result, counts, sets done, tests.
// - Average mode: test when repeat target reached; next trigger clears.
// - Burst mode: one trigger clears then converts until target, then tests.
// - Low-pass mode filters each result; tests each trigger once target reached.
// - Conversion clock divides oscillator by two times (select plus one).
// - Negative reference select at bit 4: external when set, ground when clear.
// - Positive reference: 11 fixed, 10 external, 00 supply, 01 reserved.
`timescale 1ns/10ps
`default_nettype none
module apc_post_compute import apc_pkg::*; #(
    parameter int RESULT_W = RES_W,
    parameter int ACCUM_W = ACC_W
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] bus_addr_in,
    input wire logic [DATA_W-1:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [DATA_W-1:0] bus_rdata_out,
    input wire logic trigger_in,
    input wire logic conv_done_in,
    input wire logic [RESULT_W-1:0] conv_result_in,
    output logic conv_start_out,
    output logic conv_clk_out,
    output logic [1:0] pos_ref_sel_out,
    output logic neg_ref_sel_out,
    output logic done_flag_out,
    output logic threshold_flag_out,
    output logic irq_out,
    output logic busy_out
);
    generate
        if (ACCUM_W != 16 || RESULT_W > ACCUM_W || RESULT_W < 1) begin : g_bad_width
            $error("apc_post_compute: need 16-bit accumulator and result no wider");
        end
    endgenerate

    // software-visible state
    logic [5:0] ctrl;
    logic [2:0] shift;
    logic [CS_W-1:0] clk_sel;
    logic negative_ref_select;
    logic [1:0] positive_ref_select;
    logic [CNT_W-1:0] repeat_target;
    logic [ACCUM_W-1:0] thr;
    logic [1:0] status;
    logic [1:0] mask;
    logic [5:0] next_ctrl;
    logic [2:0] next_shift;
    logic [CS_W-1:0] next_clk_sel;
    logic next_negative_ref_select;
    logic [1:0] next_positive_ref_select;
    logic [CNT_W-1:0] next_rpt;
    logic [ACCUM_W-1:0] next_thr;
    logic [1:0] next_status;
    logic [1:0] next_mask;
    logic [DATA_W-1:0] next_rdata;
    logic next_irq;
    logic [1:0] clr;

    // engine state
    apc_state_t state;
    apc_state_t next_state;
    logic [ACCUM_W-1:0] acc;
    logic [ACCUM_W-1:0] next_acc;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [1:0] left;
    logic [1:0] next_left;
    logic rearm;
    logic next_rearm;
    logic next_start;
    logic set_done;
    logic test_req;
    logic [ACCUM_W-1:0] test_val;
    logic test_strobe;
    logic [ACCUM_W-1:0] test_value;

    // working values
    apc_mode_t mode;
    logic [ACCUM_W-1:0] res_ext;
    logic [ACCUM_W-1:0] sum;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] rpt_eff;
    logic reached;

    apc_test_if #(.W(ACCUM_W)) test_bus ();

    assign mode = apc_decode_mode(ctrl[2:0]);
    assign res_ext = {{(ACCUM_W-RESULT_W){1'b0}}, conv_result_in};
    assign sum = ACCUM_W'(acc + res_ext);
    assign cnt_inc = (cnt == {CNT_W{1'b1}}) ? cnt : CNT_W'(cnt + 1'b1);
    assign rpt_eff = (repeat_target == '0) ? CNT_W'(1) : repeat_target;
    assign reached = (cnt_inc >= rpt_eff);

    // request bundle toward the comparator
    assign test_bus.strobe = test_strobe;
    assign test_bus.value = test_value;
    assign test_bus.limit = thr;
    assign test_bus.cond = ctrl[CTRL_COND_LSB +: 2];

    apc_thresh u_thresh (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .test(test_bus.cmp)
    );

    apc_clk_div #(.SEL_W(CS_W)) u_clk_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .sel_in(clk_sel),
        .conv_clk_out(conv_clk_out)
    );

    // register writes, sticky flags and read data
    always_comb begin
        next_ctrl = ctrl;
        next_shift = shift;
        next_clk_sel = clk_sel;
        next_negative_ref_select = negative_ref_select;
        next_positive_ref_select = positive_ref_select;
        next_rpt = repeat_target;
        next_thr = thr;
        next_mask = mask;
        clr = 2'h0;
        if (bus_wr_in) begin
            case (bus_addr_in)
                ADDR_CTRL: next_ctrl = bus_wdata_in[5:0];
                ADDR_CALC: next_shift = bus_wdata_in[2:0];
                ADDR_CLK: next_clk_sel = bus_wdata_in[CS_W-1:0];
                ADDR_REF: begin
                    next_negative_ref_select = bus_wdata_in[REF_NEGATIVE_REF_SELECT_BIT];
                    if (bus_wdata_in[1:0] != POSITIVE_REF_SELECT_RESERVED) begin
                        next_positive_ref_select = bus_wdata_in[1:0];
                    end
                end
                ADDR_RPT: next_rpt = bus_wdata_in;
                ADDR_THR_LO: next_thr[7:0] = bus_wdata_in;
                ADDR_THR_HI: next_thr[15:8] = bus_wdata_in;
                ADDR_STATUS: clr = bus_wdata_in[1:0];
                ADDR_MASK: next_mask = bus_wdata_in[1:0];
                default: next_mask = mask;
            endcase
        end
        // a set in the same cycle as its clear wins
        next_status = status & ~clr;
        next_status[STAT_DONE_BIT] = next_status[STAT_DONE_BIT] | set_done;
        next_status[STAT_THR_BIT] = next_status[STAT_THR_BIT] | test_bus.pass;
        next_irq = |(next_status & next_mask);
        next_rdata = 8'h00;
        if (bus_rd_in) begin
            case (bus_addr_in)
                ADDR_CTRL: next_rdata = {2'h0, ctrl};
                ADDR_CALC: next_rdata = {5'h00, shift};
                ADDR_CLK: next_rdata = {2'h0, clk_sel};
                ADDR_REF: next_rdata = {3'h0, negative_ref_select, 2'h0, positive_ref_select};
                ADDR_RPT: next_rdata = repeat_target;
                ADDR_CNT: next_rdata = cnt;
                ADDR_ACC_LO: next_rdata = acc[7:0];
                ADDR_ACC_HI: next_rdata = acc[15:8];
                ADDR_THR_LO: next_rdata = thr[7:0];
                ADDR_THR_HI: next_rdata = thr[15:8];
                ADDR_STATUS: next_rdata = {6'h00, status};
                ADDR_MASK: next_rdata = {6'h00, mask};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl <= REG_RESET[5:0];
            shift <= REG_RESET[2:0];
            clk_sel <= REG_RESET[CS_W-1:0];
            negative_ref_select <= REG_RESET[REF_NEGATIVE_REF_SELECT_BIT];
            positive_ref_select <= REG_RESET[1:0];
            repeat_target <= REG_RESET;
            thr <= {REG_RESET, REG_RESET};
            status <= REG_RESET[1:0];
            mask <= REG_RESET[1:0];
            bus_rdata_out <= REG_RESET;
            irq_out <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            shift <= next_shift;
            clk_sel <= next_clk_sel;
            negative_ref_select <= next_negative_ref_select;
            positive_ref_select <= next_positive_ref_select;
            repeat_target <= next_rpt;
            thr <= next_thr;
            status <= next_status;
            mask <= next_mask;
            bus_rdata_out <= next_rdata;
            irq_out <= next_irq;
        end
    end

    assign pos_ref_sel_out = positive_ref_select;
    assign neg_ref_sel_out = negative_ref_select;
    assign done_flag_out = status[STAT_DONE_BIT];
    assign threshold_flag_out = status[STAT_THR_BIT];

    // conversion sequencer and accumulator
    always_comb begin
        next_state = state;
        next_acc = acc;
        next_cnt = cnt;
        next_left = left;
        next_rearm = rearm;
        next_start = 1'b0;
        set_done = 1'b0;
        test_req = 1'b0;
        test_val = ACCUM_W'(sum >> shift);
        case (state)
            ST_IDLE: begin
                if (trigger_in) begin
                    next_state = ST_CONV;
                    next_left = (mode == APC_BASIC && ctrl[CTRL_DSEN_BIT]) ? 2'h2 : 2'h1;
                    if (mode == APC_BURST || (mode == APC_AVERAGE && rearm)) begin
                        next_acc = '0;
                        next_cnt = '0;
                        next_rearm = 1'b0;
                    end
                end
            end
            ST_CONV: begin
                next_start = 1'b1;
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done_in) begin
                    next_state = ST_IDLE;
                    case (mode)
                        APC_ACCUMULATE: begin
                            next_acc = sum;
                            next_cnt = cnt_inc;
                            set_done = 1'b1;
                            test_req = 1'b1;
                        end
                        APC_AVERAGE: begin
                            next_acc = sum;
                            next_cnt = cnt_inc;
                            set_done = 1'b1;
                            if (cnt_inc == rpt_eff) begin
                                test_req = 1'b1;
                                next_rearm = 1'b1;
                            end
                        end
                        APC_BURST: begin
                            next_acc = sum;
                            next_cnt = cnt_inc;
                            if (reached) begin
                                set_done = 1'b1;
                                test_req = 1'b1;
                            end else begin
                                next_state = ST_CONV;
                            end
                        end
                        APC_LOWPASS: begin
                            next_acc = ACCUM_W'(acc - (acc >> shift) + res_ext);
                            next_cnt = cnt_inc;
                            test_val = ACCUM_W'(next_acc >> shift);
                            set_done = 1'b1;
                            test_req = reached;
                        end
                        default: begin
                            next_acc = res_ext;
                            test_val = res_ext;
                            next_left = 2'(left - 1'b1);
                            if (left == 2'h1) begin
                                set_done = 1'b1;
                                test_req = 1'b1;
                            end else begin
                                next_state = ST_CONV;
                            end
                        end
                    endcase
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            acc <= '0;
            cnt <= '0;
            left <= 2'h0;
            rearm <= 1'b0;
            conv_start_out <= 1'b0;
            busy_out <= 1'b0;
            test_strobe <= 1'b0;
            test_value <= '0;
        end else begin
            state <= next_state;
            acc <= next_acc;
            cnt <= next_cnt;
            left <= next_left;
            rearm <= next_rearm;
            conv_start_out <= next_start;
            busy_out <= (next_state != ST_IDLE);
            test_strobe <= test_req;
            test_value <= test_val;
        end
    end

    state_onehot_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $onehot(state))
        else $error("sequencer state not one-hot");

    basic_double_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == ST_WAIT && conv_done_in && mode == APC_BASIC && left == 2'h2)
        |-> !set_done ##1 state == ST_CONV ##1 conv_start_out)
        else $error("basic double sample finished early");

    accum_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == ST_WAIT && conv_done_in && mode == APC_ACCUMULATE && cnt != 8'hFF)
        |=> cnt == $past(cnt) + 8'h01 && status[STAT_DONE_BIT] && test_strobe)
        else $error("accumulate step missed count or flag");

    average_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == ST_IDLE && trigger_in && mode == APC_AVERAGE && rearm)
        |=> acc == '0 && cnt == '0 && !rearm)
        else $error("average did not restart after test");

    burst_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == ST_IDLE && trigger_in && mode == APC_BURST)
        |=> acc == '0 ##1 conv_start_out)
        else $error("burst did not clear and start");

    lowpass_test_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == ST_WAIT && conv_done_in && mode == APC_LOWPASS && reached)
        |=> test_strobe && !busy_out && test_value == ACCUM_W'(acc >> shift))
        else $error("low-pass test missing");

    ref_select_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (bus_wr_in && bus_addr_in == ADDR_REF) |=> pos_ref_sel_out != POSITIVE_REF_SELECT_RESERVED
            && neg_ref_sel_out == $past(bus_wdata_in[REF_NEGATIVE_REF_SELECT_BIT]))
        else $error("reference select shows reserved code");

    thr_sticky_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(status[STAT_THR_BIT]) |-> $past(bus_wr_in && bus_addr_in == ADDR_STATUS
            && bus_wdata_in[STAT_THR_BIT] && !test_bus.pass))
        else $error("threshold flag cleared without software");

    thr_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
        test_bus.pass |=> status[STAT_THR_BIT])
        else $error("passing test did not set threshold flag");

    burst_done_c: cover property (@(posedge clk_in) disable iff (rst_in)
        mode == APC_BURST && set_done && cnt_inc > 8'h02);
    average_rearm_c: cover property (@(posedge clk_in) disable iff (rst_in)
        mode == APC_AVERAGE && rearm && trigger_in);
    lowpass_test_c: cover property (@(posedge clk_in) disable iff (rst_in)
        mode == APC_LOWPASS && test_req);
    thr_irq_c: cover property (@(posedge clk_in) disable iff (rst_in)
        status[STAT_THR_BIT] && irq_out);
endmodule : apc_post_compute
`default_nettype wire

// [sim/apc_post_compute_tb.sv]
// Purpose: self-checking bench for the post-conversion compute block
// Assumes: bench plays the converter core and the register master
// Notes: block is reset again before each mode so counts start from zero
`timescale 1ns/10ps
`default_nettype none
module apc_post_compute_tb import apc_pkg::*;;
    logic clk_in, rst_in, bus_wr_in, bus_rd_in, trigger_in, conv_done_in;
    logic [3:0] bus_addr_in;
    logic [7:0] bus_wdata_in, bus_rdata_out;
    logic [11:0] conv_result_in, res;
    logic conv_start_out, conv_clk_out, neg_ref_sel_out, done_flag_out;
    logic threshold_flag_out, irq_out, busy_out, prev_clk;
    logic [1:0] pos_ref_sel_out;
    int num_errors, n_checks, n_starts, cyc, since, last_per;
    apc_post_compute i_dut (.clk_in(clk_in), .rst_in(rst_in), .bus_addr_in(bus_addr_in),
        .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
        .bus_rdata_out(bus_rdata_out), .trigger_in(trigger_in), .conv_done_in(conv_done_in),
        .conv_result_in(conv_result_in), .conv_start_out(conv_start_out),
        .conv_clk_out(conv_clk_out), .pos_ref_sel_out(pos_ref_sel_out),
        .neg_ref_sel_out(neg_ref_sel_out), .done_flag_out(done_flag_out),
        .threshold_flag_out(threshold_flag_out), .irq_out(irq_out), .busy_out(busy_out));
    // 25 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // converter core stand-in: done with result two cycles after each start
    always @(posedge clk_in) begin
        if (conv_start_out === 1'b1) begin
            n_starts <= n_starts + 1;
            repeat (2) @(posedge clk_in);
            conv_done_in <= 1'b1;
            conv_result_in <= res;
            @(posedge clk_in);
            conv_done_in <= 1'b0;
            conv_result_in <= ~res;
        end
    end
    // conversion clock period meter and hang guard
    always @(posedge clk_in) begin
        prev_clk <= conv_clk_out;
        since <= (conv_clk_out && !prev_clk) ? 1 : since + 1;
        if (conv_clk_out && !prev_clk) last_per <= since;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end
    task automatic close_out;
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus_addr_in <= a;
        bus_wdata_in <= d;
        bus_wr_in <= 1'b1;
        @(posedge clk_in);
        bus_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        bus_addr_in <= a;
        bus_rd_in <= 1'b1;
        @(posedge clk_in);
        bus_rd_in <= 1'b0;
        #1 chk({8'h00, bus_rdata_out}, {8'h00, exp});
    endtask : rd
    task automatic flags(input logic d, input logic t, input logic i);
        chk({13'h0, done_flag_out, threshold_flag_out, irq_out}, {13'h0, d, t, i});
    endtask : flags
    // one trigger, then wait for the sequence and the flag pipeline
    task automatic trig(input logic [11:0] r);
        int c;
        res = r;
        @(posedge clk_in);
        trigger_in <= 1'b1;
        @(posedge clk_in);
        trigger_in <= 1'b0;
        c = 0;
        repeat (2) @(posedge clk_in);
        while (busy_out !== 1'b0 && c < 500) begin
            @(posedge clk_in);
            c = c + 1;
        end
        repeat (4) @(posedge clk_in);
        #1;
    endtask : trig
    task automatic restart(input logic [7:0] ctrl, input logic [7:0] repeat_target);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        n_starts = 0;
        wr(ADDR_CTRL, ctrl);
        wr(ADDR_RPT, repeat_target);
        wr(ADDR_MASK, 8'h03);
    endtask : restart
    task automatic per(input logic [7:0] s);
        wr(ADDR_CLK, s);
        repeat (300) @(posedge clk_in);
        #1 chk(16'(last_per), 16'(2 * (s + 1)));
    endtask : per
    initial begin
        {bus_wr_in, bus_rd_in, trigger_in, conv_done_in} = 4'h0;
        {bus_addr_in, bus_wdata_in, conv_result_in, res} = 36'h0;
        {num_errors, n_checks, n_starts, cyc, since, last_per} = '0;
        rst_in = 1'b1;
        prev_clk = 1'b0;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        // reset values, reference selects, unmapped read
        rd(ADDR_CLK, 8'h00);
        rd(ADDR_REF, 8'h00);
        rd(4'hF, 8'h00);
        wr(ADDR_REF, 8'h13);
        #1 chk({13'h0, neg_ref_sel_out, pos_ref_sel_out}, 16'h0007);
        wr(ADDR_REF, 8'h01);
        #1 chk({13'h0, neg_ref_sel_out, pos_ref_sel_out}, 16'h0003);
        wr(ADDR_REF, 8'h02);
        #1 chk({14'h0, pos_ref_sel_out}, {14'h0, POSITIVE_REF_SELECT_EXTERNAL});
        wr(ADDR_REF, 8'h00);
        #1 chk({14'h0, pos_ref_sel_out}, {14'h0, POSITIVE_REF_SELECT_SUPPLY});
        per(8'h00);
        per(8'h03);
        per(8'h3F);
        rd(ADDR_CLK, 8'h3F);
        // basic: double sample gives two conversions, one done
        restart(8'h38, 8'h01);
        trig(12'h005);
        chk(16'(n_starts), 16'd2);
        flags(1'b1, 1'b1, 1'b1);
        // basic, value below limit passes, above does not
        restart(8'h10, 8'h01);
        wr(ADDR_THR_LO, 8'h64);
        trig(12'h032);
        chk(16'(n_starts), 16'd1);
        flags(1'b1, 1'b1, 1'b1);
        wr(ADDR_STATUS, 8'h03);
        #1 flags(1'b0, 1'b0, 1'b0);
        trig(12'h0C8);
        flags(1'b1, 1'b0, 1'b1);
        wr(ADDR_MASK, 8'h00);
        #1 flags(1'b1, 1'b0, 1'b0);
        // unused mode code acts as basic; never condition blocks the flag
        wr(ADDR_CTRL, 8'h07);
        wr(ADDR_STATUS, 8'h03);
        trig(12'h032);
        chk(16'(n_starts), 16'd3);
        flags(1'b1, 1'b0, 1'b0);
        // accumulate: sum and count every trigger, at-or-above condition
        restart(8'h21, 8'h01);
        wr(ADDR_THR_LO, 8'h0A);
        trig(12'h005);
        flags(1'b1, 1'b0, 1'b1);
        trig(12'h007);
        rd(ADDR_ACC_LO, 8'h0C);
        rd(ADDR_CNT, 8'h02);
        flags(1'b1, 1'b1, 1'b1);
        // average: test at the target, next trigger clears
        restart(8'h32, 8'h02);
        trig(12'h004);
        flags(1'b1, 1'b0, 1'b1);
        trig(12'h006);
        flags(1'b1, 1'b1, 1'b1);
        rd(ADDR_ACC_LO, 8'h0A);
        trig(12'h001);
        rd(ADDR_ACC_LO, 8'h01);
        // burst: one trigger runs the whole target
        restart(8'h33, 8'h03);
        trig(12'h003);
        chk(16'(n_starts), 16'd3);
        rd(ADDR_ACC_LO, 8'h09);
        flags(1'b1, 1'b1, 1'b1);
        // low-pass: tests start at the target and repeat each trigger
        restart(8'h34, 8'h02);
        wr(ADDR_CALC, 8'h01);
        trig(12'h005);
        flags(1'b1, 1'b0, 1'b1);
        trig(12'h009);
        flags(1'b1, 1'b1, 1'b1);
        rd(ADDR_ACC_LO, 8'h0C);
        wr(ADDR_STATUS, 8'h02);
        #1 flags(1'b1, 1'b0, 1'b1);
        trig(12'h002);
        flags(1'b1, 1'b1, 1'b1);
        close_out();
    end
endmodule : apc_post_compute_tb
`default_nettype wire
